// >>> hdl/adcop_top.sv
// Converter digital side: sampling pipeline, output coding, output enables, power-down and APB registers
//
// The address map and the APB register port are this design's own decisions.
module adcop_top (
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter pins
	input wire logic sample_clock, // External sampling clock
	input wire logic [11:0] adc_code, // Quantised input, offset binary
	input wire logic over_pos, // Positive overdrive
	input wire logic over_neg, // Negative overdrive
	input wire logic [1:0] format_select_pin, // Decoded format-select level
	input wire logic output_enable, // Active high
	input wire logic reset_pulse, // Active high converter reset
	output logic [11:0] data_word, // Bit 11 is data_msb, bit 0 data_lsb
	output logic data_oe,
	output logic out_of_range_flag,
	output logic out_of_range_oe,
	output logic data_ready_clock,
	output logic data_ready_oe,
	output logic reference_on // Internal reference running
);
	// ==========================================================
	// Declarations
	// ==========================================================
	localparam int NSYNC = 19; // clock, code, two overdrives, format, enable, reset
	logic [NSYNC-1:0] sync1, sync2; // Pin synchronisers
	logic sclk_s, sclk_d; // Synchronised sampling clock and its delay
	logic [11:0] code_s;
	logic pos_s, neg_s, oe_s, rst_s;
	logic [1:0] fmt_s;
	logic fall_edge, rise_edge;
	logic [7:0] slow_cnt, next_slow_cnt; // Cycles since last falling edge
	logic clock_slow, next_clock_slow;
	logic [1:0] ctrl, next_ctrl; // Power-down and bypass bits
	logic ovfl, next_ovfl; // Capture overflow sticky
	logic powered_down;
	adcop_pkg::adcop_mode_t mode;
	logic [13:0] stage [adcop_pkg::PIPE_STAGES]; // {pos, neg, code} per stage
	logic [13:0] next_stage [adcop_pkg::PIPE_STAGES];
	logic [11:0] next_data_word;
	logic next_ovr;
	logic drc_raw, drc_d, next_drc_d; // Data-ready clock before and after bypass delay
	logic next_data_ready_clock;
	logic fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [adcop_pkg::FIFO_W-1:0] fifo_out_data;
	logic push;
	logic apb_wr, apb_rd;
	logic rd_first, rd_wait, next_rd_wait; // First cycle of a read access, and read answer due
	logic [31:0] next_prdata;

	// Format decoding used for both coding and clock polarity
	function automatic logic is_twc(input adcop_pkg::adcop_mode_t m);
		is_twc = (m == adcop_pkg::ADCOP_TWC_RISE) || (m == adcop_pkg::ADCOP_TWC_FALL);
	endfunction

	function automatic logic is_rise(input adcop_pkg::adcop_mode_t m);
		is_rise = (m == adcop_pkg::ADCOP_SOB_RISE) || (m == adcop_pkg::ADCOP_TWC_RISE);
	endfunction

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	// Code and clock use the same two stages so they stay aligned to each other
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sclk_d <= 1'b0;
		end else begin
			sync1 <= {sample_clock, adc_code, over_pos, over_neg, format_select_pin, output_enable, reset_pulse};
			sync2 <= sync1;
			sclk_d <= sclk_s;
		end
	end
	assign sclk_s = sync2[18];
	assign code_s = sync2[17:6];
	assign pos_s = sync2[5];
	assign neg_s = sync2[4];
	assign fmt_s = sync2[3:2];
	assign oe_s = sync2[1];
	assign rst_s = sync2[0];
	assign fall_edge = sclk_d && !sclk_s;
	assign rise_edge = !sclk_d && sclk_s;
	assign mode = adcop_pkg::adcop_mode_t'(fmt_s);

	// ==========================================================
	// Slow or missing clock detector
	// ==========================================================
	// Counter saturates, so a stopped clock holds the block down indefinitely
	always_comb begin
		next_slow_cnt = slow_cnt;
		next_clock_slow = clock_slow;
		if (fall_edge) begin
			next_slow_cnt = '0;
			next_clock_slow = 1'b0;
		end else if (slow_cnt >= adcop_pkg::SLOW_LIMIT) begin
			next_clock_slow = 1'b1;
		end else begin
			next_slow_cnt = slow_cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_cnt <= '0;
			clock_slow <= 1'b1;
		end else begin
			slow_cnt <= next_slow_cnt;
			clock_slow <= next_clock_slow;
		end
	end

	// Either the register bit or the clock detector powers the block down
	assign powered_down = ctrl[adcop_pkg::CTRL_PDN_BIT] || clock_slow;
	assign reference_on = 1'b1;

	// ==========================================================
	// Sampling pipeline
	// ==========================================================
	// One stage per falling edge; the output stage takes the last on a rising edge
	generate
		for (genvar i = 0; i < adcop_pkg::PIPE_STAGES; i++) begin : g_pipe
			localparam int PREV = (i == 0) ? 0 : i - 1; // Keeps the stage index in range at the first stage
			always_comb begin
				next_stage[i] = stage[i];
				if (rst_s) begin
					next_stage[i] = '0;
				end else if (fall_edge) begin
					next_stage[i] = (i == 0) ? {pos_s, neg_s, code_s} : stage[PREV];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stage[i] <= '0;
				end else begin
					stage[i] <= next_stage[i];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Output coding and data-ready clock
	// ==========================================================
	// Coding applies at the output so a format change takes effect on the next word
	always_comb begin
		logic [13:0] last;
		last = stage[adcop_pkg::PIPE_STAGES-1];
		next_data_word = data_word;
		next_ovr = out_of_range_flag;
		if (rst_s) begin
			next_data_word = '0;
			next_ovr = 1'b0;
		end else if (rise_edge) begin
			// One update per input cycle
			if (last[13]) begin
				next_data_word = is_twc(mode) ? adcop_pkg::TWC_POS_FS : adcop_pkg::SOB_POS_FS;
			end else if (last[12]) begin
				next_data_word = is_twc(mode) ? adcop_pkg::TWC_NEG_FS : adcop_pkg::SOB_NEG_FS;
			end else if (is_twc(mode)) begin
				next_data_word = {~last[11], last[10:0]};
			end else begin
				next_data_word = last[11:0];
			end
			if (is_twc(mode)) begin
				next_ovr = (next_data_word == adcop_pkg::TWC_POS_FS) || (next_data_word == adcop_pkg::TWC_NEG_FS);
			end else begin
				next_ovr = (next_data_word == adcop_pkg::SOB_POS_FS) || (next_data_word == adcop_pkg::SOB_NEG_FS);
			end
		end
	end

	// Rising latch: clock rises mid-word; falling latch: clock falls mid-word
	assign drc_raw = is_rise(mode) ? !sclk_s : sclk_s;
	always_comb begin
		next_drc_d = drc_raw;
		// Bypass adds one stage, standing in for the longer unlocked clock delay
		next_data_ready_clock = ctrl[adcop_pkg::CTRL_BYPASS_BIT] ? drc_d : drc_raw;
		if (rst_s) begin
			next_data_ready_clock = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_word <= '0;
			out_of_range_flag <= 1'b0;
			drc_d <= 1'b0;
			data_ready_clock <= 1'b0;
		end else begin
			data_word <= next_data_word;
			out_of_range_flag <= next_ovr;
			drc_d <= next_drc_d;
			data_ready_clock <= next_data_ready_clock;
		end
	end

	// Outputs float while disabled or powered down
	assign data_oe = oe_s && !powered_down;
	assign out_of_range_oe = oe_s && !powered_down;
	assign data_ready_oe = oe_s && !powered_down;

	// ==========================================================
	// Capture buffer
	// ==========================================================
	// A full buffer drops the word and flags it; the pins are never held back
	assign push = rise_edge && !powered_down && !rst_s;
	assign fifo_pop = rd_first && (paddr == adcop_pkg::CAPTURE_OFS);

	adcop_fifo #(
		.WIDTH(adcop_pkg::FIFO_W),
		.DEPTH(adcop_pkg::FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.clear(rst_s),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({next_ovr, next_data_word}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// ==========================================================
	// APB register file
	// ==========================================================
	// Writes answer at once; reads take one wait state so prdata is a settled flop when pready rises
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign rd_first = apb_rd && !rd_wait; // Only this cycle loads prdata and pops, never twice per read
	assign pready = pwrite || rd_wait;
	assign pslverr = psel && penable && (paddr != adcop_pkg::CTRL_OFS) && (paddr != adcop_pkg::STATUS_OFS)
		&& (paddr != adcop_pkg::CAPTURE_OFS);

	always_comb begin
		next_ctrl = ctrl;
		next_ovfl = ovfl;
		next_prdata = prdata;
		next_rd_wait = rd_first;
		if (apb_wr && paddr == adcop_pkg::CTRL_OFS) begin
			next_ctrl = pwdata[1:0];
		end
		if (apb_wr && paddr == adcop_pkg::STATUS_OFS && pwdata[adcop_pkg::ST_OVFL_BIT]) begin
			next_ovfl = 1'b0;
		end
		// Set after clear so an overflow in the clearing cycle survives
		if (push && !fifo_in_ready) begin
			next_ovfl = 1'b1;
		end
		if (rst_s) begin
			next_ctrl = adcop_pkg::CTRL_RESET;
			next_ovfl = 1'b0;
		end
		if (rd_first) begin
			next_prdata = '0;
			case (paddr)
				adcop_pkg::CTRL_OFS: begin
					next_prdata[1:0] = ctrl;
				end
				adcop_pkg::STATUS_OFS: begin
					next_prdata[adcop_pkg::ST_PDOWN_BIT] = powered_down;
					next_prdata[adcop_pkg::ST_SLOW_BIT] = clock_slow;
					next_prdata[adcop_pkg::ST_MODE_LSB +: 2] = fmt_s;
					next_prdata[adcop_pkg::ST_OVFL_BIT] = ovfl;
					next_prdata[adcop_pkg::ST_EMPTY_BIT] = !fifo_out_valid;
					next_prdata[adcop_pkg::ST_BYPASS_BIT] = ctrl[adcop_pkg::CTRL_BYPASS_BIT];
				end
				adcop_pkg::CAPTURE_OFS: begin
					next_prdata[adcop_pkg::CAP_VALID_BIT] = fifo_out_valid;
					next_prdata[adcop_pkg::FIFO_W-1:0] = fifo_out_valid ? fifo_out_data : '0;
				end
				default: begin
					next_prdata = '0; // Unmapped reads as zero with an error
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= adcop_pkg::CTRL_RESET;
			ovfl <= 1'b0;
			prdata <= '0;
			rd_wait <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			ovfl <= next_ovfl;
			prdata <= next_prdata;
			rd_wait <= next_rd_wait;
		end
	end
endmodule

// >>> hdl/adcop_pkg.sv
// Package: constants, register map and types of the converter output and power-mode block
package adcop_pkg;
	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int PCLK_PERIOD_NS = 20; // System clock period
	localparam int SLOW_LIMIT_NS = 500; // Longest sampling period at 2 MSPS
	// Cycles without a sampling edge before the clock counts as slow (rounded up)
	localparam int SLOW_LIMIT_CYC = (SLOW_LIMIT_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
	localparam int SLOW_CNT_W = 8; // Width of the slow-clock counter
	localparam logic [7:0] SLOW_LIMIT = SLOW_LIMIT_CYC[7:0];
	localparam int LATENCY_HALF = 35; // Sample to output latency in half input cycles
	// Falling-edge stages so that the output rising edge lands 17.5 cycles later
	localparam int PIPE_STAGES = (LATENCY_HALF - 1) / 2 + 1;

	// ==========================================================
	// Data layout
	// ==========================================================
	localparam int WORD_W = 12; // Output word width
	localparam int FIFO_W = WORD_W + 1; // Out-of-range flag above the word
	localparam int FIFO_DEPTH = 16; // Capture buffer depth
	localparam logic [11:0] SOB_POS_FS = 12'hFFF; // Offset binary positive limit
	localparam logic [11:0] SOB_NEG_FS = 12'h000; // Offset binary negative limit
	localparam logic [11:0] TWC_POS_FS = 12'h7FF; // Two's complement positive limit
	localparam logic [11:0] TWC_NEG_FS = 12'h800; // Two's complement negative limit

	// ==========================================================
	// Register map (byte addresses)
	// ==========================================================
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00; // Control register
	localparam logic [7:0] STATUS_OFS = 8'h04; // Status register
	localparam logic [7:0] CAPTURE_OFS = 8'h08; // Capture buffer head, read pops
	localparam int CTRL_PDN_BIT = 0; // power_down_bit
	localparam int CTRL_BYPASS_BIT = 1; // Loop bypass select
	localparam logic [1:0] CTRL_RESET = 2'h0; // Loop on, powered up
	localparam int ST_PDOWN_BIT = 0; // Block is powered down
	localparam int ST_SLOW_BIT = 1; // Sampling clock missing or slow
	localparam int ST_MODE_LSB = 2; // Decoded format mode, two bits
	localparam int ST_OVFL_BIT = 4; // Capture overflow, write one to clear
	localparam int ST_EMPTY_BIT = 5; // Capture buffer empty
	localparam int ST_BYPASS_BIT = 6; // Loop bypass in effect
	localparam int CAP_VALID_BIT = 16; // Capture read held a word

	// ==========================================================
	// Types
	// ==========================================================
	// Format modes: coding and latching edge of the data-ready clock
	typedef enum logic [1:0] {
		ADCOP_SOB_RISE,
		ADCOP_SOB_FALL,
		ADCOP_TWC_RISE,
		ADCOP_TWC_FALL
	} adcop_mode_t;
endpackage

// >>> hdl/adcop_fifo.sv
// Capture buffer: parameterised FIFO with a registered head word
module adcop_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear, // Synchronous flush
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	// ==========================================================
	// Storage behind the head register
	// ==========================================================
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH-1]; // Words behind the head
	logic [PW-1:0] wptr, next_wptr;
	logic [PW-1:0] rptr, next_rptr;
	logic [PW:0] count, next_count; // Words held in mem
	logic head_v, next_head_v; // Head register holds a word
	logic [WIDTH-1:0] next_out_data;
	logic push, pop, mem_wr, mem_rd;

	// Full counts the head too, so DEPTH words fit in all
	assign in_ready = !(head_v && (count == PW'(DEPTH - 1) + (PW+1)'(0)));
	assign out_valid = head_v;
	assign push = in_valid && in_ready;
	assign pop = head_v && out_ready;

	// Next state: head refills from mem first, bypass only when mem is empty
	always_comb begin
		next_wptr = wptr;
		next_rptr = rptr;
		next_count = count;
		next_head_v = head_v;
		next_out_data = out_data;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		if (!head_v || pop) begin
			if (count != '0) begin
				// Refill head from storage
				mem_rd = 1'b1;
				next_out_data = mem[rptr];
				next_head_v = 1'b1;
				next_rptr = (rptr == PW'(DEPTH - 2)) ? '0 : rptr + 1'b1;
			end else if (push) begin
				// Empty: incoming word goes straight to the head
				next_out_data = in_data;
				next_head_v = 1'b1;
			end else begin
				next_head_v = 1'b0;
			end
		end
		if (push && (head_v && !pop || count != '0)) begin
			mem_wr = 1'b1;
			next_wptr = (wptr == PW'(DEPTH - 2)) ? '0 : wptr + 1'b1;
		end
		next_count = count + (mem_wr ? 1'b1 : 1'b0) - (mem_rd ? 1'b1 : 1'b0);
		if (clear) begin
			next_wptr = '0;
			next_rptr = '0;
			next_count = '0;
			next_head_v = 1'b0;
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			head_v <= 1'b0;
			out_data <= '0;
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			count <= next_count;
			head_v <= next_head_v;
			out_data <= next_out_data;
		end
	end

	// Storage array has no reset; only written words are ever read
	always_ff @(posedge pclk) begin
		if (mem_wr && !clear) begin
			mem[wptr] <= in_data;
		end
	end
endmodule

// >>> dv/adcop_props.sv
// Checker: port-level properties of the converter output and power-mode block
module adcop_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic sample_clock,
	input wire logic [1:0] format_select_pin,
	input wire logic output_enable,
	input wire logic reset_pulse,
	input wire logic [11:0] data_word,
	input wire logic data_oe,
	input wire logic out_of_range_flag,
	input wire logic out_of_range_oe,
	input wire logic data_ready_clock,
	input wire logic data_ready_oe,
	input wire logic reference_on
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Helper counters
	// ==========================================================
	logic [5:0] clk_still; // Cycles since the sampling pin (or reset pulse) last moved
	logic [5:0] next_clk_still;
	logic [3:0] fmt_still; // Cycles since the format pin last moved
	logic [3:0] next_fmt_still;
	logic last_clk; // Sampling pin one cycle ago
	logic [1:0] last_fmt; // Format pin one cycle ago

	// Both counts saturate, so a long idle never wraps back to a small value
	always_comb begin
		next_clk_still = clk_still + {5'h00, clk_still != 6'h3F};
		next_fmt_still = fmt_still + {3'h0, fmt_still != 4'hF};
		if (sample_clock != last_clk || reset_pulse) begin
			next_clk_still = 6'h00;
		end
		if (format_select_pin != last_fmt) begin
			next_fmt_still = 4'h0;
		end
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_still <= 6'h00;
			fmt_still <= 4'h0;
			last_clk <= 1'b0;
			last_fmt <= 2'h0;
		end else begin
			clk_still <= next_clk_still;
			fmt_still <= next_fmt_still;
			last_clk <= sample_clock;
			last_fmt <= format_select_pin;
		end
	end

	// ==========================================================
	// Properties
	// ==========================================================
	reference_kept_a: assert property (reference_on)
		else $error("reference not running");
	pdn_floats_a: assert property (psel && penable && pwrite && paddr == adcop_pkg::CTRL_OFS && pwdata[0]
		|=> !data_oe && !out_of_range_oe && !data_ready_oe && reference_on)
		else $error("power-down write left outputs driven");
	slow_clock_pd_a: assert property (clk_still >= 6'd34 |-> !data_oe && !data_ready_oe)
		else $error("outputs driven with sampling clock stopped");
	oe_low_floats_a: assert property (!output_enable [*4] |-> !data_oe && !out_of_range_oe && !data_ready_oe)
		else $error("outputs driven with output enable low");
	pulse_clears_a: assert property (reset_pulse [*6] |-> data_word == 12'h000 && !out_of_range_flag && !data_ready_clock)
		else $error("reset pulse did not clear outputs");
	flag_at_limit_a: assert property (out_of_range_flag |-> data_word inside {12'hFFF, 12'h000, 12'h7FF, 12'h800})
		else $error("range flag high away from a limit");
	word_holds_a: assert property (disable iff (!presetn || reset_pulse)
		$changed(data_word) |=> $stable(data_word) [*3])
		else $error("data word changed twice in one input cycle");
	ready_edge_a: assert property (data_ready_oe && clk_still >= 6'd8 && fmt_still >= 4'd8
		|-> data_ready_clock == (sample_clock ^ ~format_select_pin[0]))
		else $error("data-ready clock polarity wrong for mode");
endmodule

bind adcop_top adcop_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .sample_clock,
	.format_select_pin, .output_enable, .reset_pulse, .data_word, .data_oe, .out_of_range_flag, .out_of_range_oe,
	.data_ready_clock, .data_ready_oe, .reference_on);

// >>> dv/adcop_capture_model.sv
// Capture model: far-side logic latching each sample word on the selected data-ready clock edge
module adcop_capture_model (
	input wire logic [11:0] data_word,
	input wire logic data_oe,
	input wire logic out_of_range_flag,
	input wire logic out_of_range_oe,
	input wire logic data_ready_clock,
	input wire logic data_ready_oe,
	input wire logic latch_on_fall, // High in the falling-edge modes
	output logic [11:0] cap_word,
	output logic cap_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cap_word = 12'h000;
	initial cap_flag = 1'b0;
	// Latch on the edge the mode selects; a floated line reads as the inverse of the last latch,
	// since a released bus keeps no value worth trusting
	always @(data_ready_clock) begin
		if (data_ready_oe && data_ready_clock === !latch_on_fall) begin
			cap_word <= data_oe ? data_word : ~cap_word;
			cap_flag <= out_of_range_oe ? out_of_range_flag : ~cap_flag;
		end
	end
endmodule

// >>> dv/tb.sv
// Testbench: drives the converter block over APB and its pins and checks words through a capture model
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
		$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
	typedef struct packed {logic [1:0] mode; logic [11:0] pos_exp; logic [11:0] neg_exp; logic [11:0] flip;} adcop_row_t;
	// Mode beside the saturation codes and coding flip it should give
	localparam adcop_row_t ROWS [4] = '{'{2'h0, 12'hFFF, 12'h000, 12'h000}, '{2'h1, 12'hFFF, 12'h000, 12'h000},
		'{2'h2, 12'h7FF, 12'h800, 12'h800}, '{2'h3, 12'h7FF, 12'h800, 12'h800}};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, data_oe, out_of_range_flag, out_of_range_oe, data_ready_clock, data_ready_oe;
	logic sample_clock = 1'b0, over_pos = 1'b0, over_neg = 1'b0, output_enable = 1'b1, reset_pulse = 1'b0;
	logic [11:0] adc_code = 12'h000, data_word, cap_word;
	logic [1:0] format_select_pin = 2'h0;
	logic reference_on, cap_flag, link_run = 1'b0, latch_on_fall = 1'b0;
	int failures = 0, cmp_count = 0, cycles = 0;

	adcop_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sample_clock, .adc_code, .over_pos, .over_neg, .format_select_pin, .output_enable, .reset_pulse,
		.data_word, .data_oe, .out_of_range_flag, .out_of_range_oe, .data_ready_clock, .data_ready_oe, .reference_on);
	adcop_capture_model u_cap (.data_word, .data_oe, .out_of_range_flag, .out_of_range_oe, .data_ready_clock,
		.data_ready_oe, .latch_on_fall, .cap_word, .cap_flag);

	// ==========================================================
	// Clocks and timeout
	// ==========================================================
	always #10 pclk = ~pclk;
	// Link clock, 160 ns, offset from pclk; it parks low between frames
	initial begin
		#3;
		forever begin
			#80;
			if (link_run || sample_clock) sample_clock = ~sample_clock;
		end
	end
	// Whole run is about 1100 cycles; the ceiling leaves ample room
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			print_verdict();
		end
	end

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One APB transfer; access is held until pready is sampled high, and the answer is taken at that edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata,
		output logic perr);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdata = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// 26 link cycles in one mode; the word latched after fall j is the sample of fall j-18
	task automatic run_frame(input adcop_row_t r);
		logic [11:0] exp_q [$];
		logic [11:0] code;
		logic op;
		logic on;
		link_run = 1'b1;
		for (int j = 0; j < 26; j++) begin
			@(posedge sample_clock);
			@(posedge pclk);
			code = 12'h0A5 + 12'(j * 149);
			op = (j % 7 == 3);
			on = (j % 7 == 5);
			adc_code <= code;
			over_pos <= op;
			over_neg <= on;
			exp_q.push_back(op ? r.pos_exp : (on ? r.neg_exp : code ^ r.flip));
			repeat (2) @(posedge pclk);
			if (j >= 19) begin
				`CHECK("word", exp_q[j - 19], cap_word)
				`CHECK("flag", exp_q[j - 19] == r.pos_exp || exp_q[j - 19] == r.neg_exp, cap_flag)
				`CHECK("data_oe", 1'b1, data_oe)
			end
		end
		link_run = 1'b0;
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, adcop_pkg::CTRL_OFS, 32'h0, rd, err);
		`CHECK("ctrl_reset", 32'h0, rd)
		apb(1'b0, adcop_pkg::STATUS_OFS, 32'h0, rd, err);
		`CHECK("slow_reset", 1'b1, rd[adcop_pkg::ST_SLOW_BIT])
		`CHECK("bypass_reset", 1'b0, rd[adcop_pkg::ST_BYPASS_BIT])
		`CHECK("oe_idle", 1'b0, data_oe)
		// The bench link runs far below the loop's range, so bypass first
		apb(1'b1, adcop_pkg::CTRL_OFS, 32'h2, rd, err);
		apb(1'b0, adcop_pkg::STATUS_OFS, 32'h0, rd, err);
		`CHECK("bypass_set", 1'b1, rd[adcop_pkg::ST_BYPASS_BIT])
		foreach (ROWS[i]) begin
			format_select_pin <= ROWS[i].mode;
			latch_on_fall = ROWS[i].mode[0];
			run_frame(ROWS[i]);
			apb(1'b0, adcop_pkg::STATUS_OFS, 32'h0, rd, err);
			`CHECK("mode", ROWS[i].mode, rd[adcop_pkg::ST_MODE_LSB +: 2])
		end
		// Buffer overflowed during the frames; drain it dry
		`CHECK("overflow", 1'b1, rd[adcop_pkg::ST_OVFL_BIT])
		repeat (16) begin
			apb(1'b0, adcop_pkg::CAPTURE_OFS, 32'h0, rd, err);
			`CHECK("pop_valid", 1'b1, rd[adcop_pkg::CAP_VALID_BIT])
		end
		apb(1'b0, adcop_pkg::CAPTURE_OFS, 32'h0, rd, err);
		`CHECK("empty_pop", 1'b0, rd[adcop_pkg::CAP_VALID_BIT])
		apb(1'b1, adcop_pkg::STATUS_OFS, 32'h10, rd, err);
		apb(1'b0, adcop_pkg::STATUS_OFS, 32'h0, rd, err);
		`CHECK("ovfl_clear", 2'b10, {rd[adcop_pkg::ST_EMPTY_BIT], rd[adcop_pkg::ST_OVFL_BIT]})
		apb(1'b0, 8'hFC, 32'h0, rd, err);
		`CHECK("unmapped", 33'h100000000, {err, rd})
		// Output enable and power-down while the link runs
		link_run = 1'b1;
		repeat (40) @(posedge pclk);
		`CHECK("oe_run", 1'b1, data_oe)
		output_enable <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHECK("oe_low", 3'b000, {data_oe, out_of_range_oe, data_ready_oe})
		output_enable <= 1'b1;
		apb(1'b1, adcop_pkg::CTRL_OFS, 32'h3, rd, err);
		@(posedge pclk);
		`CHECK("pd_float", 4'b0001, {data_oe, out_of_range_oe, data_ready_oe, reference_on})
		apb(1'b0, adcop_pkg::STATUS_OFS, 32'h0, rd, err);
		`CHECK("pd_status", 1'b1, rd[adcop_pkg::ST_PDOWN_BIT])
		apb(1'b1, adcop_pkg::CTRL_OFS, 32'h2, rd, err);
		@(posedge pclk);
		`CHECK("pd_exit", 1'b1, data_oe)
		reset_pulse <= 1'b1;
		repeat (8) @(posedge pclk);
		`CHECK("pulse_clear", 13'h0000, {out_of_range_flag, data_word})
		reset_pulse <= 1'b0;
		link_run = 1'b0;
		repeat (60) @(posedge pclk);
		`CHECK("slow_float", 1'b0, data_oe)
		print_verdict();
	end
endmodule
